// File: rtl/acc_conv_ctrl.sv
// Converter control: AXI4-Lite registers, conversion sequencer, pin views.
// Assumes a comparator input synchronous to aclk; Tosc equals aclk.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Bit 7 one: right justify, zero: left
// - Field 6..4 selects the reference pair
// - Result registers untouched by reset
// - Conversion ignores pin direction and analog select
// - First port analog pins read zero
// - Second port analog pins read one
// - External reference forces its pin analog
// - Go bit starts fourteen-period conversion
// - Two settling periods, twelve resolving periods
// - Clearing go aborts, loads partial result
// - Go with module-on together: go cleared
// - Codes give 2, 8, 32 periods, or RC
// - Internal reference stretches period eightfold, except RC
// - Flag at fourteenth rise, go cleared at fall
// - Channel codes 0..5 route, others reserved
module acc_conv_ctrl #(
  parameter int unsigned CNT_W = 12    // Conversion clock counter width
) (
  input  wire logic                       aclk,          // Clock
  input  wire logic                       aresetn,       // Reset, low
  input  wire logic [acc_pkg::ADDR_W-1:0] s_axi_awaddr,  // Write address
  input  wire logic                       s_axi_awvalid, // Address valid
  output logic                            s_axi_awready, // Address ready
  input  wire logic [31:0]                s_axi_wdata,   // Write data
  input  wire logic [3:0]                 s_axi_wstrb,   // Byte enables
  input  wire logic                       s_axi_wvalid,  // Data valid
  output logic                            s_axi_wready,  // Data ready
  output logic [1:0]                      s_axi_bresp,   // Write response
  output logic                            s_axi_bvalid,  // Response valid
  input  wire logic                       s_axi_bready,  // Response ready
  input  wire logic [acc_pkg::ADDR_W-1:0] s_axi_araddr,  // Read address
  input  wire logic                       s_axi_arvalid, // Address valid
  output logic                            s_axi_arready, // Address ready
  output logic [31:0]                     s_axi_rdata,   // Read data
  output logic [1:0]                      s_axi_rresp,   // Read response
  output logic                            s_axi_rvalid,  // Read valid
  input  wire logic                       s_axi_rready,  // Read ready
  input  wire logic [7:0]                 first_port_in, // First port pins
  input  wire logic [7:0]                 second_port_in,// Second port pins
  input  wire logic                       rc_level,      // RC oscillator
  input  wire logic                       cmp_above,     // Input >= DAC
  output logic [5:0]                      channel_route, // One-hot mux
  output logic [2:0]                      reference_sel, // Reference pair
  output logic                            converter_on,  // Module power
  output logic                            sample_en,     // Track input
  output logic [acc_pkg::RES_W-1:0]       dac_code,      // Trial code
  output logic [7:0]                      first_analog,  // Analog pins
  output logic [7:0]                      second_analog, // Analog pins
  output logic                            convert_done_flag // Done flag
);
  acc_pkg::acc_ctrl0_t ctrl0_r;    // Clock, channel and module-on
  acc_pkg::acc_ctrl1_t ctrl1_r;    // Format and reference
  logic [7:0]          analog_pin_select_r;    // analog_pin_select
  logic [7:0]          res_hi_r, res_lo_r; // Result high and low
  logic                go_r, flag_r; // Go bit, done flag
  acc_pkg::acc_state_t state_r;    // Sequencer state
  logic [3:0]          tad_cnt_r;  // Periods begun
  logic [acc_pkg::RES_W-1:0] sar_r, trial_r; // Trial code, trial bit
  logic                aw_have_r, w_have_r; // Address, data held
  logic [7:0]          wr_idx_r;   // Held write index
  logic [7:0]          wr_data_r;  // Held write byte
  logic                wr_en_r;    // Held byte enable
  logic [7:0]          wr_idx, rd_idx; // Write and read index
  logic                wr_do, rd_do; // Write done, read taken
  logic                int_ref;    // An internal reference in use
  logic [CNT_W-1:0]    tad_period; // Period in aclk cycles
  logic                tad_rise, tad_fall; // Period start, midpoint
  logic [acc_pkg::RES_W-1:0] sar_dec, result; // Decided code, load value
  logic                load_res;   // Load result registers
  logic [7:0]          an_first, an_second; // Analog masks
  logic [7:0]          rd_byte;    // Read mux
  logic                rd_ok;      // Mapped read
  logic                go_wr, abort; // Control zero write, abort
  assign wr_idx = wr_idx_r;
  assign rd_idx = s_axi_araddr[9:2];
  assign wr_do  = aw_have_r && w_have_r && !s_axi_bvalid;
  assign rd_do  = s_axi_arvalid && s_axi_arready;
  assign go_wr  = wr_do && wr_en_r && (wr_idx == acc_pkg::IDX_CTRL0);
  assign abort  = go_wr && !wr_data_r[1] && (state_r != acc_pkg::ACC_IDLE);
  // Write channel capture: address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      wr_idx_r  <= 8'h00;
      wr_data_r <= 8'h00;
      wr_en_r   <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        wr_idx_r  <= s_axi_awaddr[9:2];
      end else if (wr_do) begin
        aw_have_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r  <= 1'b1;
        wr_data_r <= s_axi_wdata[7:0];
        wr_en_r   <= s_axi_wstrb[0];
      end else if (wr_do) begin
        w_have_r <= 1'b0;
      end
    end
  end
  // Ready signals and write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= acc_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_have_r && !(s_axi_wvalid && s_axi_wready);
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        // Unmapped or read-only: error
        if (wr_idx == acc_pkg::IDX_CTRL0 || wr_idx == acc_pkg::IDX_CTRL1 ||
            wr_idx == acc_pkg::IDX_ANALOG_PIN_SELECT || wr_idx == acc_pkg::IDX_STATUS)
        begin
          s_axi_bresp <= acc_pkg::RESP_OKAY;
        end else begin
          s_axi_bresp <= acc_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Software registers; reserved bits kept as written
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl0_r <= acc_pkg::CTRL0_RST;
      ctrl1_r <= acc_pkg::CTRL1_RST;
      analog_pin_select_r <= acc_pkg::ANALOG_PIN_SELECT_RST;
    end else if (wr_do && wr_en_r) begin
      if (wr_idx == acc_pkg::IDX_CTRL0) begin
        ctrl0_r <= wr_data_r;
      end else if (wr_idx == acc_pkg::IDX_CTRL1) begin
        ctrl1_r <= wr_data_r;
      end else if (wr_idx == acc_pkg::IDX_ANALOG_PIN_SELECT) begin
        analog_pin_select_r <= wr_data_r;
      end
    end
  end
  // Conversion clock period
  assign int_ref = (ctrl1_r.reference == acc_pkg::REF_INT_BOTH) ||
                   (ctrl1_r.reference == acc_pkg::REF_INT_HI) ||
                   (ctrl1_r.reference == acc_pkg::REF_INT_LO) ||
                   (ctrl1_r.reference == acc_pkg::REF_INT_LOGN);
  always_comb begin
    case (ctrl0_r.clock_sel)
      2'b00:   tad_period = CNT_W'(acc_pkg::TAD_OSC_00);
      2'b01:   tad_period = CNT_W'(acc_pkg::TAD_OSC_01);
      default: tad_period = CNT_W'(acc_pkg::TAD_OSC_10);
    endcase
    if (int_ref) begin
      tad_period = CNT_W'(tad_period * acc_pkg::INTREF_MULT);
    end
  end
  acc_tad_gen #(
    .CNT_W    (CNT_W)
  ) u_tad (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .run      (state_r != acc_pkg::ACC_IDLE),
    .use_rc   (ctrl0_r.clock_sel == acc_pkg::CLK_SEL_RC),
    .period   (tad_period),
    .rc_level (rc_level),
    .rise     (tad_rise),
    .fall     (tad_fall)
  );
  // Decide the trial bit
  assign sar_dec = cmp_above ? sar_r : (sar_r & ~trial_r);

  // Go bit and sequencer; pin direction plays no part
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      go_r      <= 1'b0;
      state_r   <= acc_pkg::ACC_IDLE;
      tad_cnt_r <= 4'h0;
    end else if (go_wr) begin
      // Go with module-on rising in one write is dropped
      go_r <= wr_data_r[1] && ctrl0_r.on && wr_data_r[0];
      if (wr_data_r[1] && ctrl0_r.on && wr_data_r[0] &&
          state_r == acc_pkg::ACC_IDLE) begin
        state_r   <= acc_pkg::ACC_RUN;
        tad_cnt_r <= 4'h0; // Rewrites mid-run keep the count
      end else if (!wr_data_r[1]) begin
        state_r <= acc_pkg::ACC_IDLE;
      end
    end else if (state_r == acc_pkg::ACC_RUN && tad_rise) begin
      tad_cnt_r <= tad_cnt_r + 1'b1;
      if (tad_cnt_r == acc_pkg::TAD_LAST) begin
        state_r <= acc_pkg::ACC_DONE;
      end
    end else if (state_r == acc_pkg::ACC_DONE && tad_fall) begin
      go_r    <= 1'b0;
      state_r <= acc_pkg::ACC_IDLE;
    end
  end
  // SAR: settle, then twelve trial bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sar_r     <= '0;
      trial_r   <= '0;
      sample_en <= 1'b1;
    end else if (state_r != acc_pkg::ACC_RUN || !tad_rise) begin
      sample_en <= (state_r == acc_pkg::ACC_IDLE);
      if (state_r == acc_pkg::ACC_IDLE) begin
        sar_r   <= '0;
        trial_r <= '0;
      end
    end else if (tad_cnt_r + 1'b1 == acc_pkg::TAD_SETTLE) begin
      sample_en <= 1'b0;
    end else if (tad_cnt_r == acc_pkg::TAD_SETTLE) begin
      trial_r <= {1'b1, {(acc_pkg::RES_W-1){1'b0}}};
      sar_r   <= {1'b1, {(acc_pkg::RES_W-1){1'b0}}};
    end else begin
      trial_r <= trial_r >> 1;
      sar_r   <= sar_dec | (trial_r >> 1);
    end
  end
  assign dac_code = sar_r;
  // Load: full at the fourteenth rise, partial on abort
  assign load_res = abort || (state_r == acc_pkg::ACC_RUN && tad_rise &&
                              tad_cnt_r == acc_pkg::TAD_LAST);
  assign result   = abort ? (sar_r & ~trial_r) : sar_dec;

  // Result registers have no reset
  always_ff @(posedge aclk) begin
    if (load_res) begin
      if (ctrl1_r.justify) begin
        res_hi_r <= {4'h0, result[11:8]};
        res_lo_r <= result[7:0];
      end else begin
        res_hi_r <= result[11:4];
        res_lo_r <= {result[3:0], 4'h0};
      end
    end
  end
  // Done flag: a zero write clears, a set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_r <= 1'b0;
    end else if (load_res && !abort) begin
      flag_r <= 1'b1;
    end else if (wr_do && wr_en_r && wr_idx == acc_pkg::IDX_STATUS &&
                 !wr_data_r[0]) begin
      flag_r <= 1'b0;
    end
  end

  // Analog masks; external reference pins forced analog
  always_comb begin
    an_first  = {4'h0, analog_pin_select_r[3:0]};
    an_second = {6'h00, analog_pin_select_r[5:4]};
    if (ctrl1_r.reference == acc_pkg::REF_EXT_BOTH ||
        ctrl1_r.reference == acc_pkg::REF_EXT_HI) begin
      an_first[acc_pkg::PIN_VREF_HI] = 1'b1;
    end
    if (ctrl1_r.reference == acc_pkg::REF_EXT_BOTH ||
        ctrl1_r.reference == acc_pkg::REF_EXT_LO) begin
      an_first[acc_pkg::PIN_VREF_LO] = 1'b1;
    end
  end

  // Read multiplexer
  always_comb begin
    rd_ok   = 1'b1;
    rd_byte = 8'h00;
    if (rd_idx == acc_pkg::IDX_CTRL0) begin
      rd_byte = {ctrl0_r[7:2], go_r, ctrl0_r.on};
    end else if (rd_idx == acc_pkg::IDX_CTRL1) begin
      rd_byte = ctrl1_r;
    end else if (rd_idx == acc_pkg::IDX_RES_HI) begin
      rd_byte = res_hi_r;
    end else if (rd_idx == acc_pkg::IDX_RES_LO) begin
      rd_byte = res_lo_r;
    end else if (rd_idx == acc_pkg::IDX_ANALOG_PIN_SELECT) begin
      rd_byte = analog_pin_select_r;
    end else if (rd_idx == acc_pkg::IDX_PORT1) begin
      rd_byte = first_port_in & ~an_first;
    end else if (rd_idx == acc_pkg::IDX_PORT2) begin
      rd_byte = second_port_in | an_second;
    end else if (rd_idx == acc_pkg::IDX_STATUS) begin
      rd_byte = {7'h00, flag_r};
    end else begin
      rd_ok = 1'b0;
    end
  end
  // Read channel: one read, answered next edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= acc_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_do;
      if (rd_do) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_byte};
        s_axi_rresp  <= rd_ok ? acc_pkg::RESP_OKAY : acc_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Registered analog side outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_route     <= 6'h00;
      reference_sel     <= 3'b000;
      converter_on      <= 1'b0;
      first_analog      <= 8'h00;
      second_analog     <= 8'h00;
      convert_done_flag <= 1'b0;
    end else begin
      // Reserved channel codes route nothing
      channel_route <= ({2'b00, ctrl0_r.channel} <= acc_pkg::CHAN_LAST) ?
                       6'(6'h01 << ctrl0_r.channel) : 6'h00;
      reference_sel     <= ctrl1_r.reference;
      converter_on      <= ctrl0_r.on;
      first_analog      <= an_first;
      second_analog     <= an_second;
      convert_done_flag <= flag_r;
    end
  end
endmodule : acc_conv_ctrl
`default_nettype wire

// File: pkg/acc_pkg.sv
// Converter control package: indexes, fields, resets, counts, types.
// Assumes an AXI4-Lite master with 32-bit data and byte addressing.
package acc_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_CTRL0  = 8'h1f; // converter_control_zero
  localparam logic [7:0] IDX_CTRL1  = 8'h9f; // adc_format_reference_config
  localparam logic [7:0] IDX_RES_HI = 8'h1e; // result_high
  localparam logic [7:0] IDX_RES_LO = 8'h9e; // result_low
  localparam logic [7:0] IDX_ANALOG_PIN_SELECT  = 8'h9d; // analog_pin_select
  localparam logic [7:0] IDX_PORT1  = 8'h05; // first_port_data view
  localparam logic [7:0] IDX_PORT2  = 8'h06; // second_port_data view
  localparam logic [7:0] IDX_STATUS = 8'h0c; // convert_done_flag
  localparam int unsigned ADDR_W    = 12;    // Byte address width
  localparam logic [7:0] CTRL0_RST  = 8'h00; // Reset of control zero
  localparam logic [7:0] CTRL1_RST  = 8'h00; // Reset of control one
  localparam logic [7:0] ANALOG_PIN_SELECT_RST  = 8'h00; // All pins digital
  // Reference field codes
  localparam logic [2:0] REF_INT_BOTH = 3'b010;
  localparam logic [2:0] REF_EXT_BOTH = 3'b001;
  localparam logic [2:0] REF_EXT_HI   = 3'b011;
  localparam logic [2:0] REF_INT_HI   = 3'b100;
  localparam logic [2:0] REF_EXT_LO   = 3'b101;
  localparam logic [2:0] REF_INT_LO   = 3'b110;
  localparam logic [2:0] REF_INT_LOGN = 3'b111;
  // Conversion clock periods in oscillator periods
  localparam logic [8:0] TAD_OSC_00 = 9'd2;
  localparam logic [8:0] TAD_OSC_01 = 9'd8;
  localparam logic [8:0] TAD_OSC_10 = 9'd32;
  localparam int unsigned INTREF_MULT = 8;   // Stretch for internal refs
  localparam logic [1:0] CLK_SEL_RC = 2'b11; // Dedicated RC source
  // Sequence counts in conversion clock periods
  localparam logic [3:0] TAD_SETTLE = 4'd1;  // Settling period index
  localparam logic [3:0] TAD_LAST   = 4'd13; // Last resolving period
  localparam int unsigned RES_W     = 12;    // Result width
  localparam logic [5:0] CHAN_LAST  = 6'd5;  // Highest valid channel
  // Pins on the first port carrying external references
  localparam int unsigned PIN_VREF_HI = 3;
  localparam int unsigned PIN_VREF_LO = 2;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Control zero layout
  typedef struct packed {
    logic [1:0] clock_sel;  // conv_clock_sel
    logic [3:0] channel;    // channel_sel
    logic       go;         // go/done
    logic       on;         // converter_on
  } acc_ctrl0_t;

  // Control one layout
  typedef struct packed {
    logic       justify;    // result_justify_sel
    logic [2:0] reference;  // reference_sel
    logic [3:0] reserved;   // Stored, not used
  } acc_ctrl1_t;

  // Conversion sequencer states
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_RUN  = 2'b01,
    ACC_DONE = 2'b10
  } acc_state_t;
endpackage : acc_pkg

// File: rtl/acc_tad_gen.sv
// Conversion clock pulses: rise and midpoint of each period.
// Assumes rc_level synchronous to aclk and a period of at least 2.
`timescale 1ns/1ps
`default_nettype none
module acc_tad_gen #(
  parameter int unsigned CNT_W = 12      // Width of the period counter
) (
  input  wire logic             aclk,    // System clock
  input  wire logic             aresetn, // Synchronous reset, low
  input  wire logic             run,     // Counting while high
  input  wire logic             use_rc,  // Take edges from the RC source
  input  wire logic [CNT_W-1:0] period,  // Period in aclk cycles
  input  wire logic             rc_level,// RC oscillator level
  output logic                  rise,    // Start of a period
  output logic                  fall     // Middle of a period
);
  logic [CNT_W-1:0] cnt_r;  // Cycles into the current period
  logic             rc_q_r; // Previous RC level
  logic [CNT_W-1:0] half;   // Falling point

  assign half = period >> 1;

  // Divide the oscillator; restart whenever idle
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_r <= '0;
    end else if (cnt_r == period - 1'b1) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // Remember the RC level for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rc_q_r <= 1'b0;
    end else begin
      rc_q_r <= rc_level;
    end
  end

  // Pick the edge source
  always_comb begin
    if (use_rc) begin
      rise = run && rc_level && !rc_q_r;
      fall = run && !rc_level && rc_q_r;
    end else begin
      rise = run && (cnt_r == period - 1'b1);
      fall = run && (cnt_r == half - 1'b1);
    end
  end
endmodule : acc_tad_gen
`default_nettype wire

// File: tb/acc_conv_ctrl_asserts.sv
// Checker on the converter control ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module acc_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic [2:0]  reference_sel,
  input wire logic [7:0]  first_analog,
  input wire logic        sample_en,
  input wire logic        converter_on,
  input wire logic [5:0]  channel_route,
  input wire logic        convert_done_flag
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Bus answers
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  a_rdata_upper: assert property (s_axi_rvalid
    |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
  // Forced reference pins
  a_ref_high_pin: assert property ((reference_sel == 3'b001 ||
    reference_sel == 3'b011) |-> first_analog[3])
    else $error("high ref pin not analog");
  a_ref_low_pin: assert property ((reference_sel == 3'b001 ||
    reference_sel == 3'b101) |-> first_analog[2])
    else $error("low ref pin not analog");
  // One channel at most
  a_route_onehot: assert property ($onehot0(channel_route))
    else $error("channel route not one-hot");
  // Start needs module on
  a_run_needs_on: assert property ($fell(sample_en)
    |-> converter_on) else $error("conversion while off");
  // Flag ends a real run
  a_flag_ends_run: assert property ($rose(convert_done_flag)
    |-> !$past(sample_en, 20)) else $error("flag without conversion");
  c_done: cover property ($rose(convert_done_flag));
  c_start: cover property ($fell(sample_en));
  c_slverr: cover property (s_axi_bvalid &&
    s_axi_bresp == acc_pkg::RESP_SLVERR);
endmodule : acc_chk
bind acc_conv_ctrl acc_chk i_acc_chk (.*);
`default_nettype wire

// File: tb/acc_sar_model.sv
// Comparator and RC oscillator model on the converter's far side.
// Assumes the analog level is given as a 12-bit code.
`timescale 1ns/1ps
`default_nettype none
module acc_sar_model (
  input  wire logic        aclk,      // System clock
  input  wire logic [11:0] level,     // Analog input as a code
  input  wire logic        rc_run,    // RC source running
  input  wire logic        sample_en, // Track while high
  input  wire logic [11:0] dac_code,  // Trial code
  output logic             cmp_above, // Comparator output
  output logic             rc_level   // RC oscillator level
);
  logic [11:0] held_r;   // Sample held through conversion
  logic [2:0]  rc_cnt_r; // RC half-period counter
  logic        junk_r;   // Meaningless level while tracking
  initial begin
    held_r = 12'h000; rc_cnt_r = 3'h0; junk_r = 1'b0; rc_level = 1'b0;
  end
  // Track, then hold
  always @(posedge aclk) begin
    junk_r <= ~junk_r;
    if (sample_en) held_r <= level;
  end
  // Compare only once the sample is held
  assign cmp_above = sample_en ? junk_r : (held_r >= dac_code);
  // RC period 16 clocks (1.6 us); still when stopped
  always @(posedge aclk) if (rc_run) begin
    rc_cnt_r <= rc_cnt_r + 3'h1;
    if (rc_cnt_r == 3'h7) rc_level <= ~rc_level;
  end
endmodule : acc_sar_model
`default_nettype wire

// File: tb/acc_conv_ctrl_bench.sv
// Self-checking bench for the converter control block.
// Assumes the far-side model and bound checker.
`timescale 1ns/1ps
`default_nettype none
module acc_conv_ctrl_bench;
  logic aclk, aresetn, rc_level, cmp_above, converter_on, sample_en, rc_run;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, convert_done_flag;
  logic [11:0] s_axi_awaddr, s_axi_araddr, dac_code, level;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0]  first_port_in, second_port_in, first_analog, second_analog;
  logic [5:0]  channel_route;
  logic [2:0]  reference_sel;
  int failures, checks_done;
  acc_conv_ctrl i_acc_conv_ctrl (.*);
  acc_sar_model i_acc_sar_model (.*);
  initial begin aclk = 1'b0; forever #50 aclk = ~aclk; end
  task automatic fail(input string m);
    failures++;
    $display("[FAIL] %0t %s", $time, m);
  endtask : fail
  task automatic end_sim;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, exp, input string m);
    checks_done++;
    if (got !== exp) fail(m);
  endtask : chk
  task automatic hang(input int n);
    if (n >= 50) begin fail("bus hang"); end_sim; end
  endtask : hang
  // Write one register
  task automatic wr(input logic [7:0] idx, d);
    int n;
    logic a, w;
    @(posedge aclk);
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    a = 1'b1; w = 1'b1; n = 0;
    do begin
      @(posedge aclk); n++;
      if (s_axi_awready) begin a = 1'b0; s_axi_awvalid <= 1'b0; end
      if (s_axi_wready) begin w = 1'b0; s_axi_wvalid <= 1'b0; end
    end while ((a || w) && n < 50);
    while (!s_axi_bvalid && n < 50) begin @(posedge aclk); n++; end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    hang(n);
  endtask : wr
  // Read one register into rd_d
  task automatic rd(input logic [7:0] idx);
    int n;
    @(posedge aclk);
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin @(posedge aclk); n++; end while (!s_axi_arready && n < 50);
    s_axi_arvalid <= 1'b0;
    do begin @(posedge aclk); n++; end while (!s_axi_rvalid && n < 50);
    rd_d = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    hang(n);
  endtask : rd
  task automatic t_regs;
    rd(acc_pkg::IDX_CTRL1);
    chk(rd_d, 32'h0, "ctrl1 reset");
    wr(acc_pkg::IDX_CTRL1, 8'h8f);
    rd(acc_pkg::IDX_CTRL1);
    chk(rd_d, 32'h8f, "ctrl1 readback");
    rd(8'h40);
    chk({rd_d[29:0], rsp}, {30'h0, acc_pkg::RESP_SLVERR}, "unmapped");
    wr(acc_pkg::IDX_RES_HI, 8'h11);
    chk({30'h0, rsp}, {30'h0, acc_pkg::RESP_SLVERR}, "read-only");
    $display("regs done");
  endtask : t_regs
  // Pin views per reference
  task automatic t_pins;
    logic [7:0] ex;
    wr(acc_pkg::IDX_ANALOG_PIN_SELECT, 8'h31);
    for (int c = 0; c < 8; c++) begin
      wr(acc_pkg::IDX_CTRL1, {1'b0, c[2:0], 4'h0});
      @(posedge aclk);
      chk({29'h0, reference_sel}, c, "ref copy");
      ex = {4'h0, c == 1 || c == 3, c == 1 || c == 5, 2'b01};
      chk({24'h0, first_analog}, {24'h0, ex}, "forced pin");
      rd(acc_pkg::IDX_PORT1);
      chk(rd_d, {24'h0, ~ex}, "first port");
    end
    rd(acc_pkg::IDX_PORT2);
    chk(rd_d, 32'h03, "second port");
    chk({24'h0, second_analog}, 32'h03, "second mask");
    $display("pins done");
  endtask : t_pins
  // Full conversion of level 0x5a3
  task automatic t_conv(input logic j, input logic [1:0] sel,
                        input logic [2:0] rf, input int t);
    int n;
    level <= 12'h5a3;
    rc_run <= (sel == acc_pkg::CLK_SEL_RC);
    wr(acc_pkg::IDX_CTRL1, {j, rf, 4'h0});
    wr(acc_pkg::IDX_CTRL0, {sel, 6'h01});
    repeat (100) @(posedge aclk);
    wr(acc_pkg::IDX_CTRL0, {sel, 6'h03});
    n = 0;
    while (!convert_done_flag && n < 15 * t + 50) begin
      @(posedge aclk); n++;
    end
    if (n >= 15 * t + 50) begin fail("no done flag"); end_sim; end
    chk({31'h0, n >= (sel == 2'b11 ? 13 : 14) * t - 4 && n <= 14 * t + 4},
        32'h1, "duration");
    repeat (t) @(posedge aclk);
    rd(acc_pkg::IDX_CTRL0);
    chk(rd_d, {24'h0, sel, 6'h01}, "go cleared");
    rd(acc_pkg::IDX_RES_HI);
    chk(rd_d, j ? 32'h05 : 32'h5a, "result high");
    rd(acc_pkg::IDX_RES_LO);
    chk(rd_d, j ? 32'ha3 : 32'h30, "result low");
    wr(acc_pkg::IDX_STATUS, 8'h00);
    rc_run <= 1'b0;
    $display("conversion done");
  endtask : t_conv
  // Abort after six periods of 32 clocks
  task automatic t_abort;
    wr(acc_pkg::IDX_CTRL1, 8'h90);
    wr(acc_pkg::IDX_CTRL0, 8'h81);
    repeat (100) @(posedge aclk);
    wr(acc_pkg::IDX_CTRL0, 8'h83);
    repeat (208) @(posedge aclk);
    wr(acc_pkg::IDX_CTRL0, 8'h81);
    repeat (40) @(posedge aclk);
    chk({31'h0, convert_done_flag}, 32'h0, "flag on abort");
    rd(acc_pkg::IDX_RES_HI);
    chk(rd_d, 32'h05, "partial high");
    rd(acc_pkg::IDX_RES_LO);
    chk(rd_d, 32'h00, "partial low");
    $display("abort done");
  endtask : t_abort
  // On and go together; routing
  task automatic t_onoff;
    wr(acc_pkg::IDX_CTRL0, 8'h00);
    wr(acc_pkg::IDX_CTRL0, 8'h03);
    repeat (50) @(posedge aclk);
    chk({31'h0, sample_en}, 32'h1, "started anyway");
    rd(acc_pkg::IDX_CTRL0);
    chk(rd_d, 32'h01, "go kept");
    wr(acc_pkg::IDX_CTRL0, 8'h15);
    @(posedge aclk);
    chk({26'h0, channel_route}, 32'h20, "channel 5");
    wr(acc_pkg::IDX_CTRL0, 8'h19);
    @(posedge aclk);
    chk({26'h0, channel_route}, 32'h0, "reserved channel");
    $display("on-go done");
  endtask : t_onoff
  initial begin
    failures = 0; checks_done = 0; aresetn = 1'b0; rc_run = 1'b0;
    s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0; s_axi_rready = 1'b0; s_axi_wstrb = 4'h1;
    s_axi_awaddr = 12'h0; s_axi_araddr = 12'h0; s_axi_wdata = 32'h0;
    first_port_in = 8'hff; second_port_in = 8'h00; level = 12'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_pins;
    t_conv(1'b1, 2'b00, 3'b010, 16);
    t_conv(1'b0, 2'b10, 3'b000, 32);
    t_conv(1'b0, 2'b01, 3'b110, 64);
    t_conv(1'b1, 2'b11, 3'b000, 16);
    t_abort;
    t_onoff;
    end_sim;
  end
endmodule : acc_conv_ctrl_bench
`default_nettype wire
